/* File: rtl/eee_map.svh */
// register offsets, field positions and reset values of the low-power idle register bank
`ifndef EEE_MAP_SVH
`define EEE_MAP_SVH
`define EEE_ADDR_W            16
`define EEE_DATA_W            16
`define EEE_OFF_PCS_CTRL      16'h1000
`define EEE_OFF_CAPABILITY    16'h1014
`define EEE_OFF_WAKE_FAULT    16'h1016
`define EEE_OFF_ADVERTISE     16'h203c
`define EEE_OFF_PARTNER       16'h203d
`define EEE_OFF_IRQ_STATUS    16'h2100
`define EEE_OFF_IRQ_MASK      16'h2101
`define EEE_BIT_SOFT_RESET    15
`define EEE_BIT_RX_STOPPABLE  10
`define EEE_BIT_LPI_FAST      1
`define EEE_BIT_LPI_GIGABIT   2
`define EEE_CAP_FAST_RST      1'h1
`define EEE_CAP_GIGABIT_RST   1'h0
`define EEE_ZERO16            16'h0000
`define EEE_ONES16            16'hffff
`define EEE_IRQ_W             3
`define EEE_IRQ_WAKE_FAULT    0
`define EEE_IRQ_SATURATED     1
`define EEE_IRQ_PARTNER_CHG   2
`endif

/* File: rtl/eee_pkg.sv */
// types shared by the low-power idle register bank
package eee_pkg;
   typedef logic [15:0] eee_word_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } eee_bus_s;
   typedef struct packed {
      logic partner_chg;
      logic saturated;
      logic wake_fault;
   } eee_irq_s;
endpackage

/* File: rtl/eee_fault_counter.sv */
// saturating, clear-on-read wake fault counter
`timescale 1ns/1ps
`default_nettype none
`include "eee_map.svh"
module eee_fault_counter
   import eee_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // controls
   input  wire logic             fault,
   input  wire logic             clear_read,
   input  wire logic             soft_clear,
   // state
   output logic      [WIDTH-1:0] count,
   output logic                  at_max
);
   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;

   assign at_max = &count_q;
   assign count  = count_q;

   always_comb begin
      count_d = count_q;
      if (soft_clear) begin
         count_d = '0;
      end else if (clear_read) begin
         // a fault beside the clearing read survives as one
         count_d = fault ? WIDTH'(1) : '0;
      end else if (fault && !at_max) begin
         count_d = count_q + WIDTH'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end
endmodule // eee_fault_counter
`default_nettype wire

/* File: rtl/eee_regs.sv */
// low-power idle capability, advertisement, partner ability and wake fault register bank
//
// Contract
// - capability bit 1 reads one
// - gigabit bit and reserved bits read zero
// - count each wake sequence fault
// - reading the counter clears it afterwards
// - counter holds at all ones
// - soft reset clears the counter
// - advertise bit 1 writable, resets zero
// - partner ability bit reflects remote advertisement
// - soft reset bit self clears, resets bank; the code leaves the interrupt status and mask unchanged
// - soft reset spares vendor registers
`timescale 1ns/1ps
`default_nettype none
`include "eee_map.svh"
module eee_regs
   import eee_pkg::*;
#(
   parameter int CNT_W = `EEE_DATA_W
) (
   // clock and reset (reset held until both supplies have ramped)
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // register port
   input  wire logic [15:0] ADDR,
   input  wire logic [15:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [15:0] RDATA,
   // link events
   input  wire logic        WAKE_FAULT,
   input  wire logic        PARTNER_LPI_FAST,
   // outputs to the link logic
   output logic             LPI_FAST_ADVERTISE,
   output logic             RX_CLOCK_STOPPABLE,
   output logic             SOFT_RESET_PULSE,
   output logic             IRQ
);
   ////////////////////////////////////////////////////////////////////////////////
   // reset release
   logic      rst_meta_q;
   logic      rst_sync_q;
   logic      rst_n;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   ////////////////////////////////////////////////////////////////////////////////
   // decode
   eee_bus_s  bus;
   logic      wr_ctrl;
   logic      wr_adv;
   logic      wr_mask;
   logic      rd_cnt;
   logic      rd_stat;

   assign bus     = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   assign wr_ctrl = bus.wr && (bus.addr == `EEE_OFF_PCS_CTRL);
   assign wr_adv  = bus.wr && (bus.addr == `EEE_OFF_ADVERTISE);
   assign wr_mask = bus.wr && (bus.addr == `EEE_OFF_IRQ_MASK);
   assign rd_cnt  = bus.rd && (bus.addr == `EEE_OFF_WAKE_FAULT);
   assign rd_stat = bus.rd && (bus.addr == `EEE_OFF_IRQ_STATUS);

   ////////////////////////////////////////////////////////////////////////////////
   // soft reset: one-cycle pulse, the control bit itself never reads back as one
   logic      soft_q;
   logic      soft_set;

   assign soft_set = wr_ctrl && bus.wdata[`EEE_BIT_SOFT_RESET];

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         soft_q <= 1'b0;
      end else begin
         soft_q <= soft_set;
      end
   end
   assign SOFT_RESET_PULSE = soft_q;

   ////////////////////////////////////////////////////////////////////////////////
   // writable control bits; the interrupt mask sits outside the reset domain of
   // the soft reset, like vendor space
   logic      adv_q;
   logic      rx_stop_q;
   eee_irq_s  mask_q;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         adv_q <= 1'b0;
      end else if (soft_q) begin
         adv_q <= 1'b0;
      end else if (wr_adv) begin
         adv_q <= bus.wdata[`EEE_BIT_LPI_FAST];
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rx_stop_q <= 1'b0;
      end else if (soft_q) begin
         rx_stop_q <= 1'b0;
      end else if (wr_ctrl) begin
         rx_stop_q <= bus.wdata[`EEE_BIT_RX_STOPPABLE];
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= '0;
      end else if (wr_mask) begin
         mask_q <= bus.wdata[`EEE_IRQ_W-1:0];
      end
   end

   assign LPI_FAST_ADVERTISE = adv_q;
   assign RX_CLOCK_STOPPABLE = rx_stop_q;

   ////////////////////////////////////////////////////////////////////////////////
   // partner ability, reflected from the negotiation logic
   logic      partner_q;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         partner_q <= 1'b0;
      end else if (soft_q) begin
         partner_q <= 1'b0;
      end else begin
         partner_q <= PARTNER_LPI_FAST;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // wake fault counter
   logic [CNT_W-1:0] cnt;
   logic             cnt_max;

   eee_fault_counter #(
      .WIDTH      (CNT_W)
   ) u_cnt (
      .clk        (CLK),
      .rst_n      (rst_n),
      .fault      (WAKE_FAULT),
      .clear_read (rd_cnt),
      .soft_clear (soft_q),
      .count      (cnt),
      .at_max     (cnt_max)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt status: set wins over the clearing read
   eee_irq_s  stat_q;
   eee_irq_s  ev;

   assign ev.wake_fault  = WAKE_FAULT;
   assign ev.saturated   = WAKE_FAULT && cnt_max;
   assign ev.partner_chg = (PARTNER_LPI_FAST != partner_q) && !soft_q;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         stat_q <= '0;
      end else if (rd_stat) begin
         stat_q <= ev;
      end else begin
         stat_q <= stat_q | ev;
      end
   end

   assign IRQ = |(stat_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////////
   // read mux; unmapped addresses read zero
   eee_word_t rd_d;
   eee_word_t rdata_q;

   always_comb begin
      rd_d = `EEE_ZERO16;
      unique case (bus.addr)
         `EEE_OFF_PCS_CTRL: begin
            rd_d[`EEE_BIT_RX_STOPPABLE] = rx_stop_q;
         end
         `EEE_OFF_CAPABILITY: begin
            rd_d[`EEE_BIT_LPI_FAST]    = `EEE_CAP_FAST_RST;
            rd_d[`EEE_BIT_LPI_GIGABIT] = `EEE_CAP_GIGABIT_RST;
         end
         `EEE_OFF_WAKE_FAULT: begin
            rd_d = cnt;
         end
         `EEE_OFF_ADVERTISE: begin
            rd_d[`EEE_BIT_LPI_FAST] = adv_q;
         end
         `EEE_OFF_PARTNER: begin
            rd_d[`EEE_BIT_LPI_FAST] = partner_q;
         end
         `EEE_OFF_IRQ_STATUS: begin
            rd_d[`EEE_IRQ_W-1:0] = stat_q;
         end
         `EEE_OFF_IRQ_MASK: begin
            rd_d[`EEE_IRQ_W-1:0] = mask_q;
         end
         default: begin
            rd_d = `EEE_ZERO16;
         end
      endcase
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= `EEE_ZERO16;
      end else if (bus.rd) begin
         rdata_q <= rd_d;
      end else begin
         rdata_q <= `EEE_ZERO16;
      end
   end
   assign RDATA = rdata_q;
endmodule // eee_regs
`default_nettype wire

/* File: sim/eee_regs_properties.sv */
// concurrent checks on the ports of the low-power idle register bank
`timescale 1ns/1ps
`default_nettype none
module eee_regs_chk
   import eee_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic        CLK,
   input wire logic        RST_N,
   // register port
   input wire logic [15:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [15:0] RDATA,
   // link side
   input wire logic        WAKE_FAULT,
   input wire logic        PARTNER_LPI_FAST,
   input wire logic        LPI_FAST_ADVERTISE,
   input wire logic        RX_CLOCK_STOPPABLE,
   input wire logic        SOFT_RESET_PULSE,
   input wire logic        IRQ
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////////////
   logic soft_req_q;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) soft_req_q <= 1'b0;
      else soft_req_q <= WR && ADDR == 16'h1000 && WDATA[15];
   end
   sequence cnt_rd;
      RD && ADDR == 16'h1016;
   endsequence
   sequence quiet_rd;
      RD && ADDR == 16'h1016 && !WAKE_FAULT;
   endsequence
   sequence fault_rd;
      RD && ADDR == 16'h1016 && WAKE_FAULT && !SOFT_RESET_PULSE;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   chk_cap_value: assert property (RD && ADDR == 16'h1014 |=> RDATA == 16'h0002)
      else $error("capability read wrong");
   chk_partner_bits: assert property (RD && ADDR == 16'h203d |=> (RDATA & 16'hfffd) == 16'h0000)
      else $error("partner ability spare bits set");
   chk_adv_readback: assert property (RD && ADDR == 16'h203c |=>
      RDATA == {14'h0000, $past(LPI_FAST_ADVERTISE), 1'b0})
      else $error("advertise read differs from output");
   chk_soft_pulse: assert property (SOFT_RESET_PULSE == soft_req_q)
      else $error("soft reset pulse wrong");
   chk_soft_clear: assert property (SOFT_RESET_PULSE && !WR |=>
      !LPI_FAST_ADVERTISE && !RX_CLOCK_STOPPABLE)
      else $error("soft reset left a bit set");
   chk_fault_counted: assert property (WAKE_FAULT && !SOFT_RESET_PULSE ##1 cnt_rd |=>
      RDATA != 16'h0000)
      else $error("fault not counted");
   chk_count_cleared: assert property (quiet_rd ##1 cnt_rd |=> RDATA == 16'h0000)
      else $error("counter not cleared by read");
   chk_fault_kept: assert property (fault_rd ##1 cnt_rd |=> RDATA == 16'h0001)
      else $error("fault during read lost");
endmodule // eee_regs_chk
bind eee_regs eee_regs_chk #(.CNT_W(CNT_W)) chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .WAKE_FAULT(WAKE_FAULT),
   .PARTNER_LPI_FAST(PARTNER_LPI_FAST), .LPI_FAST_ADVERTISE(LPI_FAST_ADVERTISE),
   .RX_CLOCK_STOPPABLE(RX_CLOCK_STOPPABLE), .SOFT_RESET_PULSE(SOFT_RESET_PULSE), .IRQ(IRQ));
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the low-power idle register bank
`timescale 1ns/1ps
`default_nettype none
module testbench
   import eee_pkg::*;
;
   logic      CLK = 0, RST_N = 0, WR = 0, RD = 0, WAKE_FAULT = 0, PARTNER_LPI_FAST = 0;
   logic      IRQ, LPI_FAST_ADVERTISE, RX_CLOCK_STOPPABLE, SOFT_RESET_PULSE, rd_seen = 0;
   eee_word_t ADDR = 16'h0000, WDATA = 16'h0000, RDATA, cnt = 16'h0000;
   eee_word_t exp_q[$];
   int        miscompares = 0, check_count = 0, seed = 6140;
   always #20 CLK = ~CLK;
   eee_regs dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .WAKE_FAULT(WAKE_FAULT), .PARTNER_LPI_FAST(PARTNER_LPI_FAST),
      .LPI_FAST_ADVERTISE(LPI_FAST_ADVERTISE), .RX_CLOCK_STOPPABLE(RX_CLOCK_STOPPABLE),
      .SOFT_RESET_PULSE(SOFT_RESET_PULSE), .IRQ(IRQ));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string n, input eee_word_t seen, exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // the counter holds at all ones instead of wrapping
   function automatic eee_word_t sat(input eee_word_t c);
      return (c === 16'hffff) ? c : c + 16'h0001;
   endfunction
   // one bus cycle; the counter model clears before counting like the hardware, but clears on the soft reset write, a cycle before the pulse
   task automatic acc(input logic w, r, f, input eee_word_t a, d);
      if (r) exp_q.push_back(a === 16'h1016 ? cnt : d);
      if ((r && a === 16'h1016) || (w && a === 16'h1000 && d[15])) cnt = 16'h0000;
      if (f) cnt = sat(cnt);
      WR <= w;
      RD <= r;
      WAKE_FAULT <= f;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLK);
   endtask
   task automatic pin(input string n, ref logic v, input logic e);
      acc(0, 0, 0, 16'h0000, 16'h0000);
      @(negedge CLK);
      check(n, {15'h0000, v}, {15'h0000, e});
      @(posedge CLK);
   endtask
   task automatic conclude();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge CLK) rd_seen <= RD;
   always @(negedge CLK) if (rd_seen) check("rdata", RDATA, exp_q.pop_front());
   initial begin
      repeat (80000) @(posedge CLK);
      miscompares++;
      conclude();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      eee_word_t d;
      repeat (12) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge CLK);
      acc(1, 0, 0, 16'h1014, 16'hffff);
      acc(0, 1, 0, 16'h1014, 16'h0002);
      acc(0, 1, 0, 16'h203c, 16'h0000);
      acc(0, 1, 0, 16'h203d, 16'h0000);
      acc(0, 1, 0, 16'h1015, 16'h0000);
      acc(1, 0, 0, 16'h2101, 16'h0007);
      acc(0, 0, 1, 16'h0000, 16'h0000);
      pin("irq", IRQ, 1'b1);
      acc(0, 1, 0, 16'h2100, 16'h0001);
      pin("irq", IRQ, 1'b0);
      acc(1, 0, 0, 16'h2101, 16'h0000);
      acc(0, 0, 1, 16'h0000, 16'h0000);
      pin("irq", IRQ, 1'b0);
      repeat (40) acc(0, 0, 1'($random(seed)), 16'h0000, 16'h0000);
      acc(0, 1, 1, 16'h1016, 16'h0000);
      acc(0, 1, 0, 16'h1016, 16'h0000);
      acc(0, 1, 0, 16'h1016, 16'h0000);
      repeat (4) begin
         d = 16'($random(seed));
         acc(1, 0, 0, 16'h203c, d);
         acc(0, 1, 0, 16'h203c, d & 16'h0002);
      end
      acc(1, 0, 0, 16'h203c, 16'h0002);
      pin("adv", LPI_FAST_ADVERTISE, 1'b1);
      PARTNER_LPI_FAST <= 1'b1;
      acc(0, 0, 0, 16'h0000, 16'h0000);
      acc(0, 1, 0, 16'h203d, 16'h0002);
      acc(1, 0, 0, 16'h1000, 16'h0400);
      pin("rx_stop", RX_CLOCK_STOPPABLE, 1'b1);
      acc(0, 1, 0, 16'h1000, 16'h0400);
      // soft reset with the advertise, control, mask and counter all non-zero
      acc(1, 0, 0, 16'h2101, 16'h0005);
      acc(0, 0, 1, 16'h0000, 16'h0000);
      acc(1, 0, 0, 16'h1000, 16'h8400);
      acc(0, 0, 0, 16'h0000, 16'h0000);
      acc(0, 1, 0, 16'h203c, 16'h0000);
      acc(0, 1, 0, 16'h1000, 16'h0000);
      acc(0, 1, 0, 16'h1016, 16'h0000);
      acc(0, 1, 0, 16'h2101, 16'h0005);
      repeat (65540) acc(0, 0, 1, 16'h0000, 16'h0000);
      acc(0, 1, 0, 16'h1016, 16'h0000);
      // fault, fault while saturated, and partner change after the soft reset reload
      pin("irq", IRQ, 1'b1);
      acc(0, 1, 0, 16'h2100, 16'h0007);
      acc(0, 0, 0, 16'h0000, 16'h0000);
      acc(0, 0, 0, 16'h0000, 16'h0000);
      conclude();
   end
endmodule // testbench
`default_nettype wire
